// ---- tb/rlid_fabric.sv ----
`timescale 1ns/100ps
module rlid_fabric (
	input wire logic clk_sys,
	input wire rlid_pkg::rlid_fmt_t fmt,
	input wire logic track_req,
	input wire logic rx_word_valid,
	output rlid_pkg::rlid_ctl_t ctl,
	output logic track_voltage_temperature,
	output int word_count
);
	// Tracking is never offered in tap-count format
	assign track_voltage_temperature = track_req && (fmt == rlid_pkg::RLID_FMT_TIME);
	initial begin
		ctl = '0;
		word_count = 0;
	end
	always @(posedge clk_sys) begin
		if (rx_word_valid === 1'b1) begin
			word_count <= word_count + 1;
		end
	end
	// Tap value settles a cycle ahead of the strobe
	task automatic load(input logic [8:0] taps);
		@(negedge clk_sys);
		ctl.load_taps = taps;
		@(negedge clk_sys);
		ctl.load = 1'b1;
		@(negedge clk_sys);
		ctl = '0;
	endtask
	task automatic step(input logic up, input int cnt);
		@(negedge clk_sys);
		ctl.inc_up = up;
		ctl.inc_en = 1'b1;
		repeat (cnt) @(negedge clk_sys);
		ctl = '0;
	endtask
endmodule // rlid_fabric

// ---- tb/rlid_top_tb.sv ----
`timescale 1ns/100ps
module rlid_top_tb;
	typedef struct packed {
		rlid_pkg::rlid_fmt_t fmt;
		logic [10:0] dly;
		logic [11:0] mhz;
		logic g2;
		logic [3:0] w;
		logic [2:0] d;
		logic [8:0] taps;
		logic err;
	} rlid_row_t;
	localparam rlid_pkg::rlid_fmt_t T = rlid_pkg::RLID_FMT_TIME;
	localparam rlid_pkg::rlid_fmt_t C = rlid_pkg::RLID_FMT_COUNT;
	// Values picked so the tap arithmetic divides exactly
	localparam rlid_row_t ROWS [11] = '{
		'{C, 11'h000, 12'h320, 1'b0, 4'h8, 3'h4, 9'h000, 1'b0},
		'{C, 11'h1FF, 12'h320, 1'b0, 4'h8, 3'h4, 9'h1FF, 1'b0},
		'{C, 11'h200, 12'h320, 1'b0, 4'h8, 3'h4, 9'h000, 1'b1},
		'{T, 11'h4B0, 12'h3E8, 1'b0, 4'h8, 3'h4, 9'h0A0, 1'b0},
		'{T, 11'h000, 12'h4E2, 1'b0, 4'h8, 3'h4, 9'h008, 1'b0},
		'{T, 11'h4B0, 12'h7D0, 1'b0, 4'h8, 3'h4, 9'h140, 1'b0},
		'{T, 11'h47E, 12'h4E2, 1'b1, 4'h8, 3'h4, 9'h0C0, 1'b1},
		'{T, 11'h4E2, 12'h4E2, 1'b0, 4'h8, 3'h4, 9'h0D0, 1'b0},
		'{T, 11'h44C, 12'h4E2, 1'b1, 4'h8, 3'h4, 9'h0B8, 1'b0},
		'{C, 11'h12C, 12'h320, 1'b0, 4'h4, 3'h4, 9'h12C, 1'b1},
		'{C, 11'h005, 12'h320, 1'b0, 4'h4, 3'h2, 9'h005, 1'b0}
	};
	logic clk_sys, rst_b, ce, gen2, cal_start, pad_in, track_req;
	logic track_voltage_temperature, delay_calibrated_flag, cfg_error, delayed_bit, rx_word_valid;
	logic [8:0] tap_count, applied_taps;
	logic [8:0] held;
	logic [1:0] pad_hist;
	logic [7:0] rx_word;
	rlid_pkg::rlid_cfg_t cfg;
	rlid_pkg::rlid_ctl_t ctl;
	int word_count, failures, samples_checked, n;
	rlid_top dut (.clk_sys(clk_sys), .rst_b(rst_b), .ce(ce), .cfg(cfg), .gen2(gen2),
		.cal_start(cal_start), .track_voltage_temperature(track_voltage_temperature),
		.ctl(ctl), .pad_in(pad_in), .delay_calibrated_flag(delay_calibrated_flag),
		.tap_count(tap_count), .applied_taps(applied_taps), .cfg_error(cfg_error),
		.delayed_bit(delayed_bit), .rx_word(rx_word), .rx_word_valid(rx_word_valid));
	rlid_fabric fab (.clk_sys(clk_sys), .fmt(cfg.fmt), .track_req(track_req),
		.rx_word_valid(rx_word_valid), .ctl(ctl),
		.track_voltage_temperature(track_voltage_temperature), .word_count(word_count));
	task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_sim();
		if (failures == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic cal();
		@(negedge clk_sys);
		cal_start = 1'b1;
		@(negedge clk_sys);
		cal_start = 1'b0;
		// Skip the edges where an old flag may still stand
		repeat (2) @(negedge clk_sys);
		n = 0;
		while (delay_calibrated_flag !== 1'b1 && n < 40) begin
			@(negedge clk_sys);
			n++;
		end
		chk(delay_calibrated_flag, 1'b1);
	endtask
	task automatic rst_run();
		rst_b = 1'b0;
		repeat (16) @(negedge clk_sys);
		rst_b = 1'b1;
		chk(delay_calibrated_flag, 1'b0);
		chk(tap_count, 9'h000);
		chk(applied_taps, 9'h000);
		chk(rx_word_valid, 1'b0);
	endtask
	task automatic words(input logic [3:0] w, input logic [2:0] d, input int exp,
			input logic [7:0] pat, input logic [7:0] msk);
		cfg.width = w;
		cfg.divider = d;
		repeat (16) @(negedge clk_sys);
		n = word_count;
		repeat (64) @(negedge clk_sys);
		chk(12'(word_count - n), 12'(exp));
		// Alternating pad bits give one of two fixed words
		chk(12'(rx_word == pat || rx_word == (pat ^ msk)), 12'h001);
		// Zero taps leave the first line stage and the sampling register in the path
		chk(delayed_bit, pad_hist[1]);
	endtask
	initial begin
		// Pad is set before the first clock edge so it never toggles from unknown
		pad_in = 1'b0;
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	always @(negedge clk_sys) pad_in <= ~pad_in;
	always @(posedge clk_sys) pad_hist <= {pad_hist[0], pad_in};
	initial begin
		#400000;
		failures++;
		end_sim();
	end
	initial begin
		{rst_b, gen2, cal_start, track_req} = '0;
		ce = 1'b1;
		failures = 0;
		samples_checked = 0;
		cfg = '0;
		cfg.width = 4'h8;
		cfg.divider = 3'h4;
		rst_run();
		foreach (ROWS[i]) begin
			cfg.fmt = ROWS[i].fmt;
			cfg.delay_value = ROWS[i].dly;
			cfg.mclk_rate = ROWS[i].mhz;
			cfg.width = ROWS[i].w;
			cfg.divider = ROWS[i].d;
			gen2 = ROWS[i].g2;
			cal();
			chk(applied_taps, ROWS[i].taps);
			chk(tap_count, ROWS[i].taps);
			chk(cfg_error, ROWS[i].err);
		end
		cfg.quarter_phase = 1'b1;
		repeat (2) @(negedge clk_sys);
		chk(cfg_error, 1'b1);
		cfg.quarter_phase = 1'b0;
		repeat (2) @(negedge clk_sys);
		chk(cfg_error, 1'b0);
		fab.load(9'h0AA);
		chk(tap_count, 9'h005);
		cfg.dly_type = rlid_pkg::RLID_DLY_LOAD;
		fab.load(9'h1AB);
		chk(tap_count, 9'h1AB);
		cfg.dly_type = rlid_pkg::RLID_DLY_VARIABLE;
		cfg.delay_value = 11'h1FF;
		cal();
		fab.step(1'b1, 2);
		chk(tap_count, 9'h1FF);
		fab.step(1'b0, 3);
		chk(tap_count, 9'h1FC);
		cfg.delay_value = 11'h000;
		cal();
		fab.step(1'b0, 1);
		chk(tap_count, 9'h000);
		words(4'h4, 3'h2, 16, 8'h05, 8'h0F);
		words(4'h8, 3'h4, 8, 8'h55, 8'hFF);
		cfg = '0;
		cfg.delay_value = 11'h4B0;
		cfg.mclk_rate = 12'h3E8;
		cfg.width = 4'h8;
		cfg.divider = 3'h4;
		track_req = 1'b1;
		cal();
		chk(tap_count, 9'h0A0);
		// Faster master clock means smaller taps, so more of them
		cfg.mclk_rate = 12'h7D0;
		n = 0;
		while (tap_count === 9'h0A0 && n < 300) begin
			@(negedge clk_sys);
			n++;
		end
		held = tap_count;
		chk(held, 9'h0A1);
		// Freeze mid-ramp: a live ramp would move by one tap each cycle
		ce = 1'b0;
		repeat (20) @(negedge clk_sys);
		chk(tap_count, held);
		chk(delay_calibrated_flag, 1'b1);
		ce = 1'b1;
		n = 0;
		while (tap_count !== 9'h140 && n < 1000) begin
			@(negedge clk_sys);
			n++;
		end
		chk(tap_count, 9'h140);
		chk(applied_taps, 9'h140);
		rst_run();
		end_sim();
	end
endmodule // rlid_top_tb

// ---- verilog/rlid_deser.sv ----
`timescale 1ns/100ps
module rlid_deser (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic width8,
	input wire logic bit_in,
	output logic [7:0] word,
	output logic word_valid
);
	typedef struct packed {
		logic [7:0] shift;
		logic [2:0] cnt;
		logic [7:0] word;
		logic valid;
	} rlid_dst_t;

	rlid_dst_t st_reg;
	rlid_dst_t st_next;
	logic [2:0] last;

	always_comb begin
		last = width8 ? 3'h7 : 3'h3;
		st_next = st_reg;
		st_next.valid = 1'b0;
		st_next.shift = {st_reg.shift[6:0], bit_in};
		if (st_reg.cnt >= last) begin
			st_next.cnt = 3'h0;
			st_next.valid = 1'b1;
			// Narrow mode fills the low nibble only
			st_next.word = width8 ? {st_reg.shift[6:0], bit_in} : {4'h0, st_reg.shift[2:0], bit_in};
		end else begin
			st_next.cnt = st_reg.cnt + 3'h1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			st_reg <= '0;
		end else if (ce) begin
			st_reg <= st_next;
		end
	end

	assign word = st_reg.word;
	assign word_valid = st_reg.valid;
endmodule // rlid_deser

// ---- verilog/rlid_pkg.sv ----
package rlid_pkg;

	localparam int unsigned CLK_PERIOD_PS = 20000;
	localparam logic [8:0] TAP_MAX = 9'h1FF;
	localparam logic [10:0] TIME_MAX_GEN1_PS = 11'h4E2;
	localparam logic [10:0] TIME_MAX_GEN2_PS = 11'h44C;
	localparam logic [10:0] DELAY_RESET = 11'h000;
	localparam logic [10:0] ALIGN_DELAY_PS = 11'h032;
	// Master clock rate in MHz, range 200..2400
	localparam logic [11:0] MCLK_RATE_RESET = 12'h320;
	// Taps per master clock period used by calibration
	localparam logic [7:0] TAPS_PER_PERIOD = 8'h80;
	localparam logic [7:0] CAL_CYCLES = 8'h10;
	localparam logic [15:0] TRACK_INTERVAL = 16'h0100;
	localparam logic [3:0] WIDTH_RESET = 4'h8;
	localparam logic [2:0] DIV_FOR_W4 = 3'h2;
	localparam logic [2:0] DIV_FOR_W8 = 3'h4;

	typedef enum logic [1:0] {
		RLID_FMT_TIME = 2'h0,
		RLID_FMT_COUNT = 2'h1
	} rlid_fmt_t;

	typedef enum logic [1:0] {
		RLID_DLY_FIXED = 2'h0,
		RLID_DLY_LOAD = 2'h1,
		RLID_DLY_VARIABLE = 2'h2
	} rlid_dly_t;

	typedef enum logic [1:0] {
		RLID_ST_IDLE = 2'b00,
		RLID_ST_CAL = 2'b01,
		RLID_ST_READY = 2'b11
	} rlid_state_t;

	typedef struct packed {
		rlid_fmt_t fmt;
		rlid_dly_t dly_type;
		logic [10:0] delay_value;
		logic [11:0] mclk_rate;
		logic quarter_phase;
		logic [3:0] width;
		logic [2:0] divider;
	} rlid_cfg_t;

	typedef struct packed {
		logic load;
		logic inc_en;
		logic inc_up;
		logic [8:0] load_taps;
	} rlid_ctl_t;

endpackage

// ---- verilog/rlid_top.sv ----
`timescale 1ns/100ps
module rlid_top (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic ce,
	input wire rlid_pkg::rlid_cfg_t cfg,
	input wire logic gen2,
	input wire logic cal_start,
	input wire logic track_voltage_temperature,
	input wire rlid_pkg::rlid_ctl_t ctl,
	input wire logic pad_in,
	output logic delay_calibrated_flag,
	output logic [8:0] tap_count,
	output logic [8:0] applied_taps,
	output logic cfg_error,
	output logic delayed_bit,
	output logic [7:0] rx_word,
	output logic rx_word_valid
);
	typedef struct packed {
		rlid_pkg::rlid_state_t state;
		logic [7:0] cal_cnt;
		logic [15:0] track_cnt;
		logic [8:0] taps;
		logic [8:0] tap_target;
		logic ready;
		logic err;
		logic [511:0] line;
		logic dbit;
	} rlid_st_t;

	rlid_st_t st_reg;
	rlid_st_t st_next;
	logic [7:0] deser_word;
	logic deser_valid;
	logic [7:0] word_reg;
	logic valid_reg;

	// Taps for a ps figure: ps * taps_per_period * MHz / 1e6 (taps_per_period taps span one clock period)
	function automatic logic [8:0] ps_to_taps(input logic [10:0] ps, input logic [11:0] mhz);
		logic [31:0] prod;
		logic [31:0] q;
		prod = 32'(ps) * 32'(rlid_pkg::TAPS_PER_PERIOD) * 32'(mhz);
		q = prod / 32'h000F4240;
		ps_to_taps = (q > 32'(rlid_pkg::TAP_MAX)) ? rlid_pkg::TAP_MAX : q[8:0];
	endfunction

	function automatic logic cfg_bad(input rlid_pkg::rlid_cfg_t c, input logic g2, input logic vt);
		logic [10:0] lim;
		lim = g2 ? rlid_pkg::TIME_MAX_GEN2_PS : rlid_pkg::TIME_MAX_GEN1_PS;
		cfg_bad = 1'b0;
		if (c.fmt == rlid_pkg::RLID_FMT_COUNT) begin
			cfg_bad = (c.delay_value > 11'(rlid_pkg::TAP_MAX)) || vt;
		end else if (c.delay_value > lim) begin
			cfg_bad = 1'b1;
		end
		if (c.quarter_phase) begin
			cfg_bad = 1'b1;
		end
		if (!((c.width == 4'h4 && c.divider == rlid_pkg::DIV_FOR_W4)
				|| (c.width == 4'h8 && c.divider == rlid_pkg::DIV_FOR_W8))) begin
			cfg_bad = 1'b1;
		end
		if (c.dly_type == 2'h3) begin
			cfg_bad = 1'b1;
		end
	endfunction

	always_comb begin
		st_next = st_reg;
		st_next.err = cfg_bad(cfg, gen2, track_voltage_temperature);
		st_next.line = {st_reg.line[510:0], pad_in};
		st_next.dbit = st_reg.line[st_reg.taps];
		unique case (st_reg.state)
			rlid_pkg::RLID_ST_IDLE: begin
				st_next.ready = 1'b0;
				if (cal_start) begin
					st_next.state = rlid_pkg::RLID_ST_CAL;
					st_next.cal_cnt = '0;
				end
			end
			rlid_pkg::RLID_ST_CAL: begin
				st_next.cal_cnt = st_reg.cal_cnt + 8'h01;
				if (st_reg.cal_cnt == rlid_pkg::CAL_CYCLES - 8'h01) begin
					st_next.state = rlid_pkg::RLID_ST_READY;
					st_next.ready = 1'b1;
					st_next.track_cnt = '0;
					if (cfg.fmt == rlid_pkg::RLID_FMT_COUNT) begin
						st_next.tap_target = cfg.delay_value[8:0];
					end else begin
						st_next.tap_target = ps_to_taps(cfg.delay_value + rlid_pkg::ALIGN_DELAY_PS,
							cfg.mclk_rate);
					end
					st_next.taps = st_next.tap_target;
				end
			end
			rlid_pkg::RLID_ST_READY: begin
				// Tracking nudges one tap per cycle toward a target refreshed each interval to avoid glitching data
				if (cfg.fmt == rlid_pkg::RLID_FMT_TIME && track_voltage_temperature) begin
					st_next.track_cnt = st_reg.track_cnt + 16'h0001;
					if (st_reg.track_cnt == rlid_pkg::TRACK_INTERVAL) begin
						st_next.track_cnt = '0;
						st_next.tap_target = ps_to_taps(cfg.delay_value + rlid_pkg::ALIGN_DELAY_PS,
							cfg.mclk_rate);
					end
					if (st_reg.taps < st_reg.tap_target) begin
						st_next.taps = st_reg.taps + 9'h001;
					end else if (st_reg.taps > st_reg.tap_target) begin
						st_next.taps = st_reg.taps - 9'h001;
					end
				end else begin
					unique case (cfg.dly_type)
						rlid_pkg::RLID_DLY_LOAD: begin
							if (ctl.load) begin
								st_next.taps = ctl.load_taps;
							end
						end
						rlid_pkg::RLID_DLY_VARIABLE: begin
							if (ctl.inc_en && ctl.inc_up && st_reg.taps != rlid_pkg::TAP_MAX) begin
								st_next.taps = st_reg.taps + 9'h001;
							end else if (ctl.inc_en && !ctl.inc_up && st_reg.taps != 9'h000) begin
								st_next.taps = st_reg.taps - 9'h001;
							end
						end
						default: begin
						end
					endcase
				end
				if (cal_start) begin
					st_next.state = rlid_pkg::RLID_ST_CAL;
					st_next.cal_cnt = '0;
					st_next.ready = 1'b0;
				end
			end
			default: begin
				st_next.state = rlid_pkg::RLID_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			st_reg <= '0;
			word_reg <= '0;
			valid_reg <= 1'b0;
		end else if (ce) begin
			st_reg <= st_next;
			word_reg <= deser_word;
			valid_reg <= deser_valid;
		end
	end

	rlid_deser u_deser (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.ce(ce),
		.width8(cfg.width != 4'h4),
		.bit_in(st_reg.dbit),
		.word(deser_word),
		.word_valid(deser_valid)
	);

	assign delay_calibrated_flag = st_reg.ready;
	assign tap_count = st_reg.taps;
	assign applied_taps = st_reg.tap_target;
	assign cfg_error = st_reg.err;
	assign delayed_bit = st_reg.dbit;
	assign rx_word = word_reg;
	assign rx_word_valid = valid_reg;

	property p_cal_len;
		@(posedge clk_sys) disable iff (!rst_b || !ce)
		(st_reg.state == rlid_pkg::RLID_ST_IDLE && cal_start) |=> !delay_calibrated_flag [*8];
	endproperty
	a_cal_len: assert property (p_cal_len) else $error("flag rose too early");

	property p_count_taps;
		@(posedge clk_sys) disable iff (!rst_b)
		(ce && st_reg.state == rlid_pkg::RLID_ST_CAL && st_reg.cal_cnt == 8'h0F
			&& cfg.fmt == rlid_pkg::RLID_FMT_COUNT) |=> tap_count == $past(cfg.delay_value[8:0]);
	endproperty
	a_count_taps: assert property (p_count_taps) else $error("count taps wrong");

	property p_time_taps;
		@(posedge clk_sys) disable iff (!rst_b)
		(ce && st_reg.state == rlid_pkg::RLID_ST_CAL && st_reg.cal_cnt == 8'h0F
			&& cfg.fmt == rlid_pkg::RLID_FMT_TIME) |=> delay_calibrated_flag
			&& applied_taps == ps_to_taps($past(cfg.delay_value) + rlid_pkg::ALIGN_DELAY_PS,
			$past(cfg.mclk_rate));
	endproperty
	a_time_taps: assert property (p_time_taps) else $error("time taps wrong");

	property p_track_step;
		@(posedge clk_sys) disable iff (!rst_b || !ce)
		(st_reg.state == rlid_pkg::RLID_ST_READY && track_voltage_temperature) |=>
			(tap_count - $past(tap_count) <= 9'h001) || ($past(tap_count) - tap_count <= 9'h001);
	endproperty
	a_track_step: assert property (p_track_step) else $error("tracking jumped");

	property p_fixed_hold;
		@(posedge clk_sys) disable iff (!rst_b || !ce)
		(st_reg.state == rlid_pkg::RLID_ST_READY && !cal_start && !track_voltage_temperature
			&& cfg.dly_type == rlid_pkg::RLID_DLY_FIXED) |=> $stable(tap_count);
	endproperty
	a_fixed_hold: assert property (p_fixed_hold) else $error("fixed delay moved");

	property p_load;
		@(posedge clk_sys) disable iff (!rst_b || !ce)
		(st_reg.state == rlid_pkg::RLID_ST_READY && !cal_start && !track_voltage_temperature
			&& cfg.dly_type == rlid_pkg::RLID_DLY_LOAD && ctl.load) |=>
			tap_count == $past(ctl.load_taps);
	endproperty
	a_load: assert property (p_load) else $error("load not applied");

	property p_range;
		@(posedge clk_sys) disable iff (!rst_b || !ce)
		(cfg.fmt == rlid_pkg::RLID_FMT_COUNT && cfg.delay_value > 11'h1FF) |=> cfg_error;
	endproperty
	a_range: assert property (p_range) else $error("range not flagged");

	property p_phase;
		@(posedge clk_sys) disable iff (!rst_b || !ce)
		cfg.quarter_phase |=> cfg_error;
	endproperty
	a_phase: assert property (p_phase) else $error("quarter phase not flagged");

	property p_width;
		@(posedge clk_sys) disable iff (!rst_b || !ce)
		((cfg.width == 4'h8 && cfg.divider != rlid_pkg::DIV_FOR_W8)
			|| (cfg.width == 4'h4 && cfg.divider != rlid_pkg::DIV_FOR_W4)) |=> cfg_error;
	endproperty
	a_width: assert property (p_width) else $error("width pairing not flagged");
endmodule // rlid_top
